// ==== emulator_reset_init.sv ====
// Reset and initialization sequencer for the emulator evaluation module
//
// Notes on behaviour
// - Every source resets the emulated core; the external pin only in standalone mode
// - Power-up only enables breakpoint and powerdown breaks
// - Power-up only clears all breakpoint bits
// - Board-only command keeps break status
// - Power-up only clears instruction-executed bits
// - Power-up clears trace enables and pointer
// - Power-up and switch set free-running trace
// - Power-up and switch clear cycle trigger
// - Power-up only presets count address zero
// - Power-up only sets 91.0 us unit
// - Standalone mode: external reset, start at zero
// - Two-clock low reset gives full reset; a one-clock low is filtered
// - Both mode switches on select standalone
// - Bank two switch 1 selects variant
// - Bank two switches 3, 4 pick clock
`timescale 1ns/1ps
module emulator_reset_init
(
  // Clock and reset
  input  wire logic        i_core_clk,
  input  wire logic        i_rst,
  // Initialization sources
  input  wire logic        i_power_up,
  input  wire logic        i_reset_switch,
  input  wire logic        i_cmd_reset_full,
  input  wire logic        i_cmd_reset_board,
  input  wire logic        i_ext_reset_n,
  // Configuration switches
  input  wire logic        i_mode1_sw,
  input  wire logic        i_mode2_sw,
  input  wire logic        i_bank2_sw1,
  input  wire logic        i_bank2_sw3,
  input  wire logic        i_bank2_sw4,
  // Debug events from the evaluation logic
  input  wire logic        i_break_event,
  input  wire logic [1:0]  i_break_cause,
  input  wire logic        i_exec_valid,
  input  wire logic [11:0] i_exec_addr,
  // Debugger settings writes
  input  wire logic        i_set_bp_valid,
  input  wire logic [11:0] i_set_bp_addr,
  input  wire logic        i_set_bp_val,
  input  wire logic        i_break_cond_we,
  input  wire logic [1:0]  i_break_cond_wdata,
  input  wire logic        i_trace_trig_we,
  input  wire logic [1:0]  i_trace_trig_wdata,
  input  wire logic        i_cyc_trig_we,
  input  wire logic [11:0] i_cyc_start_wdata,
  input  wire logic [11:0] i_cyc_stop_wdata,
  input  wire logic        i_cyc_en_wdata,
  // Debug state outputs
  output logic             o_core_reset,
  output logic [11:0]      o_core_start_addr,
  output logic             o_breakpoint_bit_break_en,
  output logic             o_powerdown_break_en,
  output logic [1:0]       o_break_status,
  output logic [1:0]       o_trace_trigger,
  output logic [9:0]       o_trace_ptr,
  output logic [11:0]      o_cyc_start_addr,
  output logic [11:0]      o_cyc_stop_addr,
  output logic             o_cyc_count_en,
  output logic [11:0]      o_count_addr,
  output logic [15:0]      o_time_unit,
  output logic             o_standalone_eval_mode,
  output logic             o_variant_sel,
  output logic             o_high_speed_clk,
  output logic             o_init_busy
);

  // Synchronised sources, their edge history and one-cycle requests
  logic pwr_lvl, sw_lvl, ext_rst_lvl;
  logic pwr_prev_q, sw_prev_q, ext_prev_q;
  logic pwr_req, sw_req, ext_req;

  // Power-up and switch are pins; three-stage synchronised
  reset_pin_sync u_sync_pwr
  (
    .i_core_clk (i_core_clk),
    .i_rst      (i_rst),
    .i_pin      (~i_power_up),
    .i_rst_val  (1'b0),
    .o_level    (pwr_lvl)
  );

  reset_pin_sync u_sync_sw
  (
    .i_core_clk (i_core_clk),
    .i_rst      (i_rst),
    .i_pin      (~i_reset_switch),
    .i_rst_val  (1'b0),
    .o_level    (sw_lvl)
  );

  // Active-low external reset; level is high while asserted
  reset_pin_sync u_sync_ext
  (
    .i_core_clk (i_core_clk),
    .i_rst      (i_rst),
    .i_pin      (i_ext_reset_n),
    .i_rst_val  (1'b0),
    .o_level    (ext_rst_lvl)
  );

  // Rising-edge detect of each filtered level
  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      pwr_prev_q <= 1'b0;
      sw_prev_q  <= 1'b0;
      ext_prev_q <= 1'b0;
    end
    else
    begin
      pwr_prev_q <= pwr_lvl;
      sw_prev_q  <= sw_lvl;
      ext_prev_q <= ext_rst_lvl;
    end
  end

  assign pwr_req = pwr_lvl & ~pwr_prev_q;
  assign sw_req  = sw_lvl & ~sw_prev_q;
  assign ext_req = ext_rst_lvl & ~ext_prev_q & o_standalone_eval_mode;

  // Debug bit memory
  debug_bits_if dbg ();

  debug_bits_mem u_bits
  (
    .i_core_clk (i_core_clk),
    .bus        (dbg)
  );

  // Sequencer state
  reset_init_pkg::seq_state_e st_q, st_d;
  logic [11:0] sweep_q, sweep_d;
  logic [3:0]  core_cnt_q, core_cnt_d;
  logic        pend_pwr_q, pend_pwr_d;
  logic        pend_sw_q, pend_sw_d;
  logic        pend_full_q, pend_full_d;
  logic        pend_brd_q, pend_brd_d;
  logic        any_req;
  logic        busy_q, busy_d;

  assign any_req = pwr_req | sw_req | ext_req | i_cmd_reset_full | i_cmd_reset_board;

  // Debug settings state
  logic        bp_en_q, bp_en_d;
  logic        pd_en_q, pd_en_d;
  logic [1:0]  brk_stat_q, brk_stat_d;
  logic [1:0]  trig_q, trig_d;
  logic [9:0]  tptr_q, tptr_d;
  logic [11:0] cyc_start_q, cyc_start_d;
  logic [11:0] cyc_stop_q, cyc_stop_d;
  logic        cyc_en_q, cyc_en_d;
  logic [11:0] cnt_addr_q, cnt_addr_d;
  logic [15:0] tunit_q, tunit_d;
  logic        eva_q, var_q, hs_q;

  // Sequencer: latch sources, apply in one cycle, sweep bits, pulse core reset
  always_comb
  begin
    st_d        = st_q;
    sweep_d     = sweep_q;
    core_cnt_d  = core_cnt_q;
    pend_pwr_d  = pend_pwr_q | pwr_req;
    pend_sw_d   = pend_sw_q | sw_req;
    pend_full_d = pend_full_q | i_cmd_reset_full | ext_req;
    pend_brd_d  = pend_brd_q | i_cmd_reset_board;
    case (st_q)
      reset_init_pkg::ST_IDLE:
      begin
        if (any_req)
        begin
          st_d = reset_init_pkg::ST_APPLY;
        end
      end
      reset_init_pkg::ST_APPLY:
      begin
        sweep_d = '0;
        if (pend_pwr_q)
        begin
          st_d = reset_init_pkg::ST_SWEEP;
        end
        else
        begin
          st_d = reset_init_pkg::ST_CORE;
        end
        core_cnt_d  = reset_init_pkg::CORE_RST_CYCLES;
        pend_pwr_d  = pwr_req;
        pend_sw_d   = sw_req;
        pend_full_d = i_cmd_reset_full | ext_req;
        pend_brd_d  = i_cmd_reset_board;
      end
      reset_init_pkg::ST_SWEEP:
      begin
        sweep_d = sweep_q + 12'h001;
        if (sweep_q == 12'hfff)
        begin
          st_d = reset_init_pkg::ST_CORE;
        end
      end
      reset_init_pkg::ST_CORE:
      begin
        core_cnt_d = core_cnt_q - 4'h1;
        if (core_cnt_q == 4'h1)
        begin
          // Requests latched earlier in the run must rerun without a fresh edge
          st_d = reset_init_pkg::ST_IDLE;
          if (pend_pwr_d || pend_sw_d || pend_full_d || pend_brd_d)
          begin
            st_d = reset_init_pkg::ST_APPLY;
          end
        end
      end
      default:
      begin
        st_d = reset_init_pkg::ST_IDLE;
      end
    endcase
    // Busy is registered so the core reset output comes from a flop
    busy_d = (st_d != reset_init_pkg::ST_IDLE);
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      st_q        <= reset_init_pkg::ST_IDLE;
      busy_q      <= 1'b0;
      sweep_q     <= 12'h000;
      core_cnt_q  <= 4'h0;
      pend_pwr_q  <= 1'b0;
      pend_sw_q   <= 1'b0;
      pend_full_q <= 1'b0;
      pend_brd_q  <= 1'b0;
    end
    else
    begin
      st_q        <= st_d;
      busy_q      <= busy_d;
      sweep_q     <= sweep_d;
      core_cnt_q  <= core_cnt_d;
      pend_pwr_q  <= pend_pwr_d;
      pend_sw_q   <= pend_sw_d;
      pend_full_q <= pend_full_d;
      pend_brd_q  <= pend_brd_d;
    end
  end

  // Memory port: sweep clears all bits; otherwise execution and breakpoint updates
  always_comb
  begin
    dbg.wr_en   = 1'b0;
    dbg.wr_addr = i_exec_addr;
    dbg.wr_data = '0;
    dbg.rd_addr = i_set_bp_valid ? i_set_bp_addr : i_exec_addr;
    if (st_q == reset_init_pkg::ST_SWEEP)
    begin
      dbg.wr_en   = 1'b1;
      dbg.wr_addr = sweep_q;
    end
    else if (i_set_bp_valid)
    begin
      // Read-modify-write uses last read data; settings writes are rare and slow
      dbg.wr_en   = 1'b1;
      dbg.wr_addr = i_set_bp_addr;
      dbg.wr_data = dbg.rd_data;
      dbg.wr_data[reset_init_pkg::BIT_BREAK] = i_set_bp_val;
    end
    else if (i_exec_valid)
    begin
      dbg.wr_en   = 1'b1;
      dbg.wr_data = dbg.rd_data;
      dbg.wr_data[reset_init_pkg::BIT_EXEC] = 1'b1;
    end
  end

  // Settings: apply the selected initialization for each source in one cycle
  always_comb
  begin
    bp_en_d     = i_break_cond_we ? i_break_cond_wdata[0] : bp_en_q;
    pd_en_d     = i_break_cond_we ? i_break_cond_wdata[1] : pd_en_q;
    brk_stat_d  = (i_break_event && st_q == reset_init_pkg::ST_IDLE) ? i_break_cause : brk_stat_q;
    trig_d      = i_trace_trig_we ? i_trace_trig_wdata : trig_q;
    tptr_d      = i_exec_valid ? tptr_q + 10'h001 : tptr_q;
    cyc_start_d = i_cyc_trig_we ? i_cyc_start_wdata : cyc_start_q;
    cyc_stop_d  = i_cyc_trig_we ? i_cyc_stop_wdata : cyc_stop_q;
    cyc_en_d    = i_cyc_trig_we ? i_cyc_en_wdata : cyc_en_q;
    cnt_addr_d  = cnt_addr_q;
    tunit_d     = tunit_q;
    if (st_q == reset_init_pkg::ST_APPLY)
    begin
      if (pend_pwr_q || pend_sw_q || pend_full_q)
      begin
        brk_stat_d = reset_init_pkg::BREAK_STATUS_NONE;
      end
      if (pend_pwr_q || pend_sw_q)
      begin
        trig_d      = reset_init_pkg::TRACE_TRIG_FREE;
        cyc_start_d = reset_init_pkg::CYC_ADDR_RST;
        cyc_stop_d  = reset_init_pkg::CYC_ADDR_RST;
        cyc_en_d    = 1'b0;
      end
      if (pend_pwr_q)
      begin
        bp_en_d    = 1'b1;
        pd_en_d    = 1'b1;
        tptr_d     = reset_init_pkg::TRACE_PTR_RST;
        cnt_addr_d = reset_init_pkg::COUNT_ADDR_RST;
        tunit_d    = reset_init_pkg::TIME_UNIT_RST;
      end
    end
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      bp_en_q     <= 1'b1;
      pd_en_q     <= 1'b1;
      brk_stat_q  <= reset_init_pkg::BREAK_STATUS_NONE;
      trig_q      <= reset_init_pkg::TRACE_TRIG_FREE;
      tptr_q      <= reset_init_pkg::TRACE_PTR_RST;
      cyc_start_q <= reset_init_pkg::CYC_ADDR_RST;
      cyc_stop_q  <= reset_init_pkg::CYC_ADDR_RST;
      cyc_en_q    <= 1'b0;
      cnt_addr_q  <= reset_init_pkg::COUNT_ADDR_RST;
      tunit_q     <= reset_init_pkg::TIME_UNIT_RST;
    end
    else
    begin
      bp_en_q     <= bp_en_d;
      pd_en_q     <= pd_en_d;
      brk_stat_q  <= brk_stat_d;
      trig_q      <= trig_d;
      tptr_q      <= tptr_d;
      cyc_start_q <= cyc_start_d;
      cyc_stop_q  <= cyc_stop_d;
      cyc_en_q    <= cyc_en_d;
      cnt_addr_q  <= cnt_addr_d;
      tunit_q     <= tunit_d;
    end
  end

  // Configuration switches are static straps, sampled every cycle
  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      eva_q <= 1'b0;
      var_q <= 1'b0;
      hs_q  <= 1'b0;
    end
    else
    begin
      eva_q <= i_mode2_sw & i_mode1_sw;
      var_q <= i_bank2_sw1;
      hs_q  <= i_bank2_sw3 & i_bank2_sw4;
    end
  end

  // Outputs straight from flip-flops, except the constant core start address
  assign o_core_reset              = busy_q;
  assign o_core_start_addr         = reset_init_pkg::CORE_START_ADDR;
  assign o_breakpoint_bit_break_en = bp_en_q;
  assign o_powerdown_break_en      = pd_en_q;
  assign o_break_status            = brk_stat_q;
  assign o_trace_trigger           = trig_q;
  assign o_trace_ptr               = tptr_q;
  assign o_cyc_start_addr          = cyc_start_q;
  assign o_cyc_stop_addr           = cyc_stop_q;
  assign o_cyc_count_en            = cyc_en_q;
  assign o_count_addr              = cnt_addr_q;
  assign o_time_unit               = tunit_q;
  assign o_standalone_eval_mode    = eva_q;
  assign o_variant_sel             = var_q;
  assign o_high_speed_clk          = hs_q;
  assign o_init_busy               = busy_q;

endmodule

// ==== reset_init_pkg.sv ====
// Shared constants for the emulator reset and initialization block
package reset_init_pkg;

  // Address space sizes
  localparam int unsigned ADDR_W      = 12;
  localparam int unsigned MEM_WORDS   = 4096;
  localparam int unsigned TRACE_PTR_W = 10;

  // Values after initialization
  localparam logic [11:0] COUNT_ADDR_RST    = 12'h000;
  localparam logic [11:0] CORE_START_ADDR   = 12'h000;
  localparam logic [11:0] CYC_ADDR_RST      = 12'h000;
  localparam logic [9:0]  TRACE_PTR_RST     = 10'h000;
  localparam logic [1:0]  BREAK_STATUS_NONE = 2'h0;
  localparam logic [1:0]  TRACE_TRIG_FREE   = 2'h0;
  // Time unit in tenths of a microsecond per count (91.0 us)
  localparam logic [15:0] TIME_UNIT_RST     = 16'h038e;

  // Clock cycles spent in ST_CORE; core reset also covers the apply cycle
  localparam logic [3:0]  CORE_RST_CYCLES   = 4'h8;

  // Field positions of the per-address debug bit word
  localparam int unsigned BIT_BREAK = 0;
  localparam int unsigned BIT_EXEC  = 1;
  localparam int unsigned BIT_TRACE = 2;
  localparam int unsigned DBG_W     = 3;

  // Sequencer states
  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_APPLY = 4'b0010,
    ST_SWEEP = 4'b0100,
    ST_CORE  = 4'b1000
  } seq_state_e;

endpackage

// ==== debug_bits_if.sv ====
// Port bundle between the sequencer and the debug bit memory
`timescale 1ns/1ps
interface debug_bits_if;
  logic                                  wr_en;
  logic [reset_init_pkg::ADDR_W-1:0]     wr_addr;
  logic [reset_init_pkg::DBG_W-1:0]      wr_data;
  logic [reset_init_pkg::ADDR_W-1:0]     rd_addr;
  logic [reset_init_pkg::DBG_W-1:0]      rd_data;

  modport master (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
  modport mem    (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface

// ==== debug_bits_mem.sv ====
// Per-address breakpoint, executed and trace enable bits
`timescale 1ns/1ps
module debug_bits_mem
(
  // Clock
  input wire logic i_core_clk,
  // Access port
  debug_bits_if.mem bus
);

  logic [reset_init_pkg::DBG_W-1:0] mem_q [reset_init_pkg::MEM_WORDS];
  logic [reset_init_pkg::DBG_W-1:0] rd_q;

  // Memory has no reset: the sequencer sweeps it clear instead
  always_ff @(posedge i_core_clk)
  begin
    if (bus.wr_en)
    begin
      mem_q[bus.wr_addr] <= bus.wr_data;
    end
    rd_q <= mem_q[bus.rd_addr];
  end

  assign bus.rd_data = rd_q;

endmodule

// ==== reset_pin_sync.sv ====
// Three-stage synchroniser with agreement filter for one pin
`timescale 1ns/1ps
module reset_pin_sync
(
  // Clock and reset
  input  wire logic i_core_clk,
  input  wire logic i_rst,
  // Pin and filtered level
  input  wire logic i_pin,
  input  wire logic i_rst_val,
  output logic      o_level
);

  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic lvl_q;
  logic lvl_d;

  // Level changes only once stages two and three agree
  always_comb
  begin
    lvl_d = lvl_q;
    if (s2_q == s3_q)
    begin
      lvl_d = s3_q;
    end
  end

  // Reset loads the idle level through a constant-driven input
  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      s1_q  <= 1'b1;
      s2_q  <= 1'b1;
      s3_q  <= 1'b1;
      lvl_q <= 1'b1;
    end
    else
    begin
      s1_q  <= i_pin;
      s2_q  <= s1_q;
      s3_q  <= s2_q;
      lvl_q <= lvl_d;
    end
  end

  assign o_level = lvl_q ^ ~i_rst_val;

endmodule

// ==== emulator_reset_init_sva.sv ====
// Port-level assertions for the reset and initialization sequencer
`timescale 1ns/1ps
module emulator_reset_init_sva
(
  // Clock and reset
  input wire logic        i_core_clk,
  input wire logic        i_rst,
  // Watched inputs
  input wire logic        i_cmd_reset_full,
  input wire logic        i_cmd_reset_board,
  input wire logic        i_break_event,
  input wire logic        i_mode1_sw,
  input wire logic        i_mode2_sw,
  input wire logic        i_bank2_sw3,
  input wire logic        i_bank2_sw4,
  // Watched outputs
  input wire logic        o_core_reset,
  input wire logic        o_init_busy,
  input wire logic [11:0] o_core_start_addr,
  input wire logic [1:0]  o_break_status,
  input wire logic [11:0] o_count_addr,
  input wire logic [15:0] o_time_unit,
  input wire logic        o_standalone_eval_mode,
  input wire logic        o_high_speed_clk
);
  // One clock domain, so clocking and reset are given once
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);

  // Busy and core reset are one level seen twice
  busy_mirror_a: assert property (o_init_busy == o_core_reset)
    else $error("busy differs from core reset");
  // A command seen while idle starts the core reset next cycle
  cmd_apply_a: assert property ((i_cmd_reset_full || i_cmd_reset_board) && !o_core_reset |=> o_core_reset)
    else $error("command did not start core reset");
  // Core reset is never shorter than CORE_RST_CYCLES cycles
  core_len_a: assert property ($rose(o_core_reset) |-> o_core_reset [*8])
    else $error("core reset too short");
  // Full command clears the break status two cycles on
  full_clear_a: assert property (i_cmd_reset_full && !o_core_reset |-> ##2 o_break_status == 2'h0)
    else $error("full command left break status");
  // Board command alone keeps the break status
  board_keep_a: assert property (i_cmd_reset_board && !i_cmd_reset_full && !i_break_event && !o_core_reset
    |-> ##2 o_break_status == $past(o_break_status, 2))
    else $error("board command changed break status");
  // Core always restarts from address zero
  start_zero_a: assert property (o_core_start_addr == reset_init_pkg::CORE_START_ADDR)
    else $error("core start address not zero");
  // Nothing but power-up touches the time unit and count address
  unit_count_a: assert property (o_time_unit == reset_init_pkg::TIME_UNIT_RST
    && o_count_addr == reset_init_pkg::COUNT_ADDR_RST)
    else $error("time unit or count address wrong");
  // Settled mode straps decide standalone mode; eight cycles cover the strap flops
  mode_sel_a: assert property ($stable({i_mode1_sw, i_mode2_sw}) [*8]
    |-> o_standalone_eval_mode == (i_mode1_sw && i_mode2_sw))
    else $error("standalone mode does not follow straps");
  // Settled clock straps decide the clock supply
  clk_sel_a: assert property ($stable({i_bank2_sw3, i_bank2_sw4}) [*8]
    |-> o_high_speed_clk == (i_bank2_sw3 && i_bank2_sw4))
    else $error("clock select does not follow straps");
endmodule

bind emulator_reset_init emulator_reset_init_sva u_emulator_reset_init_sva (.*);

// ==== emulator_reset_host.sv ====
// Model of the user system that drives the active-low reset pin
`timescale 1ns/1ps
module emulator_reset_host
(
  // Clock
  input  wire logic       i_core_clk,
  // Control from the bench
  input  wire logic       i_osc_running,
  input  wire logic       i_pulse_req,
  input  wire logic [7:0] i_pulse_len,
  // Reset pin
  output logic            o_ext_reset_n
);
  logic [7:0] low_cnt_q;

  initial o_ext_reset_n = 1'b0;
  initial low_cnt_q = 8'h00;

  // Low from power application; a pulse lasts at least one clock even for a zero length
  always @(posedge i_core_clk)
  begin
    if (!i_osc_running)
    begin
      o_ext_reset_n <= 1'b0;
      low_cnt_q     <= 8'h00;
    end
    else if (i_pulse_req)
    begin
      o_ext_reset_n <= 1'b0;
      low_cnt_q     <= (i_pulse_len == 8'h00) ? 8'h00 : i_pulse_len - 8'h01;
    end
    else if (low_cnt_q != 8'h00)
      low_cnt_q <= low_cnt_q - 8'h01;
    else
      o_ext_reset_n <= 1'b1;
  end
endmodule

// ==== emulator_reset_init_bench.sv ====
// Self-checking bench for the reset and initialization sequencer
`timescale 1ns/1ps
`define CHECK(got, exp) begin comparisons++; if ((got) !== (exp)) begin num_errors++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module emulator_reset_init_bench;
  logic        i_core_clk, i_rst, i_power_up, i_reset_switch, i_cmd_reset_full, i_cmd_reset_board;
  logic        i_mode1_sw, i_mode2_sw, i_bank2_sw1, i_bank2_sw3, i_bank2_sw4, i_break_event, i_exec_valid;
  logic        i_set_bp_valid, i_set_bp_val, i_break_cond_we, i_trace_trig_we, i_cyc_trig_we, i_cyc_en_wdata;
  logic [1:0]  i_break_cause, i_break_cond_wdata, i_trace_trig_wdata, o_break_status, o_trace_trigger;
  logic [11:0] i_exec_addr, i_set_bp_addr, i_cyc_start_wdata, i_cyc_stop_wdata, o_core_start_addr;
  logic [11:0] o_cyc_start_addr, o_cyc_stop_addr, o_count_addr;
  logic        o_core_reset, o_breakpoint_bit_break_en, o_powerdown_break_en, o_cyc_count_en;
  logic        o_standalone_eval_mode, o_variant_sel, o_high_speed_clk, o_init_busy, i_ext_reset_n;
  logic [9:0]  o_trace_ptr;
  logic [15:0] o_time_unit;
  logic        osc_running, pulse_req;
  logic [7:0]  pulse_len;
  int          num_errors, comparisons, seen;

  emulator_reset_init u_emulator_reset_init (.*);
  emulator_reset_host u_emulator_reset_host (.i_core_clk(i_core_clk), .i_osc_running(osc_running),
    .i_pulse_req(pulse_req), .i_pulse_len(pulse_len), .o_ext_reset_n(i_ext_reset_n));

  // Free-running core clock
  always #5 i_core_clk = ~i_core_clk;

  // Inputs move a fixed delay after the edge so no race with the design
  task automatic tick();
    @(posedge i_core_clk);
    #1;
  endtask

  // Waits a bounded time for core reset, then counts its length
  task automatic measure(input int exp_len);
    int n;
    int w;
    n = 0;
    w = 0;
    while (o_core_reset !== 1'b1 && w < 20)
    begin
      tick();
      w++;
    end
    while (o_core_reset === 1'b1 && n < 5000)
    begin
      tick();
      n++;
    end
    `CHECK(n, exp_len)
  endtask

  // One-cycle reset command, full or board-only
  task automatic pulse_cmd(input logic full);
    i_cmd_reset_full  = full;
    i_cmd_reset_board = ~full;
    tick();
    i_cmd_reset_full  = 1'b0;
    i_cmd_reset_board = 1'b0;
  endtask

  // Moves every writable setting off its default and raises a break
  task automatic set_all();
    {i_break_cond_we, i_trace_trig_we, i_cyc_trig_we, i_break_event, i_set_bp_valid, i_exec_valid} = 6'h3f;
    tick();
    {i_break_cond_we, i_trace_trig_we, i_cyc_trig_we, i_break_event, i_set_bp_valid, i_exec_valid} = 6'h00;
    tick();
  endtask

  // Compares the visible debug state with what the sources should leave
  task automatic check_state(input logic [1:0] cond, input logic [1:0] status, input logic [1:0] trig,
                             input logic [11:0] cs, input logic [11:0] ce, input logic en);
    tick();
    `CHECK({o_powerdown_break_en, o_breakpoint_bit_break_en}, cond)
    `CHECK(o_break_status, status)
    `CHECK(o_trace_trigger, trig)
    `CHECK({o_cyc_start_addr, o_cyc_stop_addr, o_cyc_count_en}, {cs, ce, en})
    `CHECK({o_count_addr, o_time_unit}, {12'h000, 16'h038e})
  endtask

  // Summary and verdict, the single end of the run
  task automatic results();
    $display("comparisons=%0d num_errors=%0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Watchdog sized well past the power-up sweep
  initial
  begin
    repeat (20000) @(posedge i_core_clk);
    num_errors++;
    results();
  end

  // Main sequence
  initial
  begin
    {i_core_clk, i_power_up, i_reset_switch, i_cmd_reset_full, i_cmd_reset_board, i_mode1_sw, i_mode2_sw} = '0;
    {i_bank2_sw1, i_bank2_sw3, i_bank2_sw4, i_exec_valid, i_set_bp_valid, i_break_cond_we} = '0;
    {i_trace_trig_we, i_cyc_trig_we, i_break_event, osc_running, pulse_req} = '0;
    {i_exec_addr, i_set_bp_addr, i_set_bp_val} = {12'h7ff, 12'hfff, 1'b1};
    {i_break_cause, i_break_cond_wdata, i_trace_trig_wdata, i_cyc_en_wdata} = {2'h3, 2'h0, 2'h2, 1'b1};
    {i_cyc_start_wdata, i_cyc_stop_wdata, pulse_len} = {12'h123, 12'h456, 8'h04};
    num_errors = 0;
    comparisons = 0;
    i_rst = 1'b1;
    repeat (2) @(posedge i_core_clk);
    #1;
    i_rst = 1'b0;
    osc_running = 1'b1;
    check_state(2'h3, 2'h0, 2'h0, 12'h000, 12'h000, 1'b0);
    set_all();
    check_state(2'h0, 2'h3, 2'h2, 12'h123, 12'h456, 1'b1);
    // Board-only command keeps break status, trace and cycle triggers
    pulse_cmd(1'b0);
    measure(9);
    check_state(2'h0, 2'h3, 2'h2, 12'h123, 12'h456, 1'b1);
    // Full command clears break status only
    pulse_cmd(1'b1);
    measure(9);
    check_state(2'h0, 2'h0, 2'h2, 12'h123, 12'h456, 1'b1);
    // Reset switch also frees the trace and clears the cycle trigger, break conditions stay
    set_all();
    i_reset_switch = 1'b1;
    measure(9);
    i_reset_switch = 1'b0;
    check_state(2'h0, 2'h0, 2'h0, 12'h000, 12'h000, 1'b0);
    repeat (8) tick();
    // Power-up restores everything and sweeps all 4096 words of debug bits
    set_all();
    i_power_up = 1'b1;
    measure(4105);
    i_power_up = 1'b0;
    check_state(2'h3, 2'h0, 2'h0, 12'h000, 12'h000, 1'b0);
    `CHECK(o_trace_ptr, 10'h000)
    // All four settings of each strap pair, with the pairs driven together
    for (int k = 0; k < 4; k++)
    begin
      {i_mode2_sw, i_mode1_sw} = k[1:0];
      {i_bank2_sw4, i_bank2_sw3} = k[1:0];
      i_bank2_sw1 = k[0];
      repeat (10) tick();
      `CHECK(o_standalone_eval_mode, (k == 3))
      `CHECK(o_high_speed_clk, (k == 3))
      `CHECK(o_variant_sel, k[0])
    end
    // Standalone mode: external pin reset acts as a full reset
    set_all();
    pulse_req = 1'b1;
    tick();
    pulse_req = 1'b0;
    measure(9);
    check_state(2'h0, 2'h0, 2'h2, 12'h123, 12'h456, 1'b1);
    `CHECK(o_core_start_addr, 12'h000)
    // Out of standalone mode the pin is ignored
    i_mode1_sw = 1'b0;
    repeat (10) tick();
    pulse_req = 1'b1;
    tick();
    pulse_req = 1'b0;
    seen = 0;
    repeat (20)
    begin
      tick();
      if (o_core_reset !== 1'b0)
        seen++;
    end
    `CHECK(seen, 0)
    results();
  end
endmodule
